/* rtl/iftm_trip_manager.sv */
// What this block does
// RULE1: any fault halts operation or warns, and its code is shown on the keypad
// RULE2: level faults drop when cleared and are not kept in history
// RULE3: latched faults clear only when gone and then reset is applied
// RULE4: fatal faults hold until a power cycle, whatever the condition
// RULE5: several simultaneous trips: only the highest priority one is displayed
// RULE6: warnings are readable through a dedicated register
// RULE7: motor overload latches only while its enable is nonzero
// RULE8: output current above 200 percent latches overcurrent
// RULE9: bus voltage above threshold latches overvoltage
// RULE10: bus undervoltage is level class, released on recovery
// RULE11: output ground fault above threshold latches
// RULE12: thermal model trip latches only while thermal enable is nonzero
// RULE13: open output phase latches only when phase select bit 1 is set
// RULE14: drive overload model, 150 percent for one minute, latches
// RULE15: unstable power or charging fault is fatal
// RULE16: power back within one second of undervoltage may give charging trip
// RULE17: heat sink over limit latches
// RULE18: temperature sensor failure latches
// RULE19: fan error trips and clears when resolved; the code only warns for it and holds it until a trip reset
// RULE20: external trip A latches when its input closes, polarity honoured
// RULE21: external trip B latches when its input opens, polarity honoured
// RULE22: internal link down over 500 ms latches
// RULE23: brake current below level with a relay set to brake function latches
// RULE24: io board trip at power-up until linked, and after 2 s loss
// RULE25: fixed priority encoder, lowest source index wins
//
// The plain strobed port and the register addresses were decided locally.
`default_nettype none
`include "iftm_defines.svh"

module iftm_trip_manager
    import iftm_pkg::*;
#(
    parameter int LINK_LOSS_CYC = `IFTM_LINK_LOSS_CYC,
    parameter int IO_LOSS_CYC   = `IFTM_IO_LOSS_CYC,
    parameter int RECHARGE_CYC  = `IFTM_RECHARGE_CYC
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire logic              enable_in,
    // fault detections and trip reset request
    input  wire iftm_fault_in_type fault_in,
    input  wire logic              reset_trip_in,
    // register port
    input  wire logic [3:0]        addr_in,
    input  wire logic [31:0]       wdata_in,
    input  wire logic              write_in,
    input  wire logic              read_in,
    output logic [31:0]            rdata_out,
    // trip outputs
    output logic                   halt_out,
    output logic                   warning_out,
    output logic [4:0]             keypad_code_out,
    output logic [16:0]            active_out
);
    localparam logic [16:0] LEVEL_MASK = 17'h00010; // undervoltage
    localparam logic [16:0] FATAL_MASK = 17'h00001; // charging
    localparam logic [16:0] WARN_MASK  = 17'h10000; // fan warns, motor keeps running

    iftm_state_type st_r;
    iftm_state_type st_nxt;

    logic [16:0] cond;
    logic        ext_closed_a;
    logic        ext_closed_b;
    logic        brake_relay;
    logic        sw_reset;
    logic [16:0] next_active;

    // ------------------------------------------------------------
    // fault conditions
    // ------------------------------------------------------------
    always_comb begin
        // sink polarity: pin low means closed, source: pin high
        ext_closed_a = st_r.cfg[`IFTM_CFG_SRC_POL_BIT] ? fault_in.ext_a_pin : ~fault_in.ext_a_pin;
        ext_closed_b = st_r.cfg[`IFTM_CFG_SRC_POL_BIT] ? fault_in.ext_b_pin : ~fault_in.ext_b_pin;
        brake_relay = (st_r.cfg[`IFTM_CFG_RLY1_HI:`IFTM_CFG_RLY1_LO] == `IFTM_RELAY_BRAKE_FN)
                   || (st_r.cfg[`IFTM_CFG_RLY2_HI:`IFTM_CFG_RLY2_LO] == `IFTM_RELAY_BRAKE_FN);
        cond = '0;
        // a short outage may trip charging on return
        cond[SRC_CHARGE]   = fault_in.charge_fault
                           || (st_r.uv_recent && st_r.prev_uv && !fault_in.undervoltage); // RULE15 RULE16
        cond[SRC_OVERCUR]  = fault_in.overcurrent_200;                                       // RULE8
        cond[SRC_GROUND]   = fault_in.ground_fault;                                          // RULE11
        cond[SRC_OVERVOLT] = fault_in.overvoltage;                                           // RULE9
        cond[SRC_UNDERVLT] = fault_in.undervoltage;                                          // RULE10
        // power-up wait trips only while the io link is still missing
        cond[SRC_IOBOARD]  = ((st_r.io_state == IO_WAIT) && !fault_in.io_link_up)
                           || (st_r.io_state == IO_LOST);                                    // RULE24
        // a restored link removes the cause at once, so a reset in that cycle clears
        cond[SRC_LINK]     = !fault_in.link_up && (st_r.link_cnt >= 32'(LINK_LOSS_CYC));     // RULE22
        cond[SRC_SENSOR]   = fault_in.temp_sensor_bad;                                       // RULE18
        cond[SRC_HEATSINK] = fault_in.heatsink_hot;                                          // RULE17
        cond[SRC_DRV_OVL]  = fault_in.drive_overload;                                        // RULE14
        cond[SRC_MOT_OVL]  = fault_in.overload_level && st_r.cfg[`IFTM_CFG_OVL_EN_BIT];      // RULE7
        cond[SRC_THERMAL]  = fault_in.thermal_model && st_r.cfg[`IFTM_CFG_THERM_EN_BIT];     // RULE12
        cond[SRC_PHASE]    = (|fault_in.phase_open)
                           && st_r.cfg[`IFTM_CFG_PHASE_LO + `IFTM_CFG_PHASE_BIT];             // RULE13
        cond[SRC_EXT_A]    = ext_closed_a && st_r.cfg[`IFTM_CFG_EXTA_EN_BIT];                // RULE20
        cond[SRC_EXT_B]    = !ext_closed_b && st_r.cfg[`IFTM_CFG_EXTB_EN_BIT];               // RULE21
        cond[SRC_BRAKE]    = fault_in.brake_active && fault_in.below_brake_current
                           && brake_relay;                                                   // RULE23
        cond[SRC_FAN]      = fault_in.fan_error;                                             // RULE19
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt   = st_r;
        sw_reset = reset_trip_in || (write_in && addr_in == `IFTM_ADDR_CTRL
                                     && wdata_in[`IFTM_CTRL_RESET_BIT]);

        // latched bits clear only with reset and the cause gone; set wins
        next_active = cond | (st_r.active & FATAL_MASK)                                      // RULE4
                    | (st_r.active & ~LEVEL_MASK & ~FATAL_MASK & {17{~sw_reset}});            // RULE3
        next_active = (next_active & ~LEVEL_MASK) | (cond & LEVEL_MASK);                     // RULE2
        st_nxt.active  = next_active;
        st_nxt.history = st_r.history | (cond & ~LEVEL_MASK);                                // RULE2

        // only the trip of highest priority reaches the keypad
        st_nxt.code = `IFTM_CODE_NONE;
        for (int i = `IFTM_NUM_SRC - 1; i >= 0; i--) begin
            if (next_active[i]) begin
                st_nxt.code = 5'(i);                                                         // RULE5 RULE25
            end
        end
        st_nxt.halt    = |(next_active & ~WARN_MASK);                                        // RULE1
        st_nxt.warning = |(next_active & WARN_MASK);                                         // RULE1

        // internal link loss timer
        if (fault_in.link_up) begin
            st_nxt.link_cnt = '0;
        end else if (st_r.link_cnt < 32'(LINK_LOSS_CYC)) begin
            st_nxt.link_cnt = st_r.link_cnt + 32'h1;                                         // RULE22
        end

        // io board link supervision
        unique case (st_r.io_state)
            IO_WAIT: begin
                if (fault_in.io_link_up) begin
                    st_nxt.io_state = IO_UP;
                end
            end
            IO_UP: begin
                if (fault_in.io_link_up) begin
                    st_nxt.io_cnt = '0;
                end else if (st_r.io_cnt + 32'h1 >= 32'(IO_LOSS_CYC)) begin
                    st_nxt.io_state = IO_LOST;                                               // RULE24
                end else begin
                    st_nxt.io_cnt = st_r.io_cnt + 32'h1;
                end
            end
            IO_LOST: begin
                if (fault_in.io_link_up && sw_reset) begin
                    st_nxt.io_state = IO_UP;
                    st_nxt.io_cnt   = '0;
                end
            end
            default: st_nxt.io_state = IO_WAIT;
        endcase

        // window after undervoltage in which a return counts as too quick
        st_nxt.prev_uv = fault_in.undervoltage;
        if (fault_in.undervoltage && !st_r.prev_uv) begin
            st_nxt.uv_cnt    = '0;
            st_nxt.uv_recent = 1'b1;
        end else if (st_r.uv_recent) begin
            if (st_r.uv_cnt + 32'h1 >= 32'(RECHARGE_CYC)) begin
                st_nxt.uv_recent = 1'b0;                                                     // RULE16
            end else begin
                st_nxt.uv_cnt = st_r.uv_cnt + 32'h1;
            end
        end

        // ------------------------------------------------------------
        // register port
        // ------------------------------------------------------------
        if (write_in && addr_in == `IFTM_ADDR_CONFIG) begin
            st_nxt.cfg = wdata_in;
        end
        st_nxt.rdata = '0;
        if (read_in) begin
            unique case (addr_in)
                `IFTM_ADDR_CONFIG:  st_nxt.rdata = st_r.cfg;
                `IFTM_ADDR_ACTIVE:  st_nxt.rdata = {15'h0, st_r.active};
                `IFTM_ADDR_WARN:    st_nxt.rdata = {15'h0, st_r.active & WARN_MASK};          // RULE6
                `IFTM_ADDR_CODE:    st_nxt.rdata = {27'h0, st_r.code};
                `IFTM_ADDR_HISTORY: st_nxt.rdata = {15'h0, st_r.history};
                `IFTM_ADDR_LEVEL:   st_nxt.rdata = {15'h0, cond};
                default:            st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_r          <= '0;
            st_r.code     <= `IFTM_CODE_NONE;
            st_r.cfg      <= `IFTM_CFG_RESET;
            st_r.io_state <= IO_WAIT;
        end else if (enable_in) begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out       = st_r.rdata;
    assign halt_out        = st_r.halt;
    assign warning_out     = st_r.warning;
    assign keypad_code_out = st_r.code;
    assign active_out      = st_r.active;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_fatal_hold;
        @(posedge clk_in) disable iff (reset_in)
        (active_out[SRC_CHARGE] && enable_in) |=> active_out[SRC_CHARGE];
    endproperty
    a_fatal_hold: assert property (p_fatal_hold) else $error("fatal trip dropped"); // RULE4

    property p_level_drop;
        @(posedge clk_in) disable iff (reset_in)
        (enable_in && !fault_in.undervoltage) |=> !active_out[SRC_UNDERVLT];
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("level trip held"); // RULE10

    logic history_bit_uv;
    assign history_bit_uv = st_r.history[SRC_UNDERVLT];
    property p_level_hist;
        @(posedge clk_in) disable iff (reset_in)
        !history_bit_uv;
    endproperty
    a_level_hist: assert property (p_level_hist) else $error("level trip in history"); // RULE2

    property p_latch_hold;
        @(posedge clk_in) disable iff (reset_in)
        (active_out[SRC_OVERCUR] && enable_in && !reset_trip_in && !write_in) |=> active_out[SRC_OVERCUR];
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched trip lost"); // RULE3

    property p_overcur_set;
        @(posedge clk_in) disable iff (reset_in)
        (enable_in && fault_in.overcurrent_200) |=> active_out[SRC_OVERCUR] && halt_out;
    endproperty
    a_overcur_set: assert property (p_overcur_set) else $error("overcurrent not tripped"); // RULE8

    property p_ovl_gate;
        @(posedge clk_in) disable iff (reset_in)
        (enable_in && fault_in.overload_level && st_r.cfg[`IFTM_CFG_OVL_EN_BIT]) |=> active_out[SRC_MOT_OVL];
    endproperty
    a_ovl_gate: assert property (p_ovl_gate) else $error("overload not tripped"); // RULE7

    property p_priority;
        @(posedge clk_in) disable iff (reset_in)
        (active_out[SRC_CHARGE]) |-> keypad_code_out == 5'h00;
    endproperty
    a_priority: assert property (p_priority) else $error("wrong keypad code"); // RULE5

    property p_fan_warn;
        @(posedge clk_in) disable iff (reset_in)
        (active_out == WARN_MASK) |-> warning_out && !halt_out;
    endproperty
    a_fan_warn: assert property (p_fan_warn) else $error("fan should only warn"); // RULE19

    property p_read_lat;
        @(posedge clk_in) disable iff (reset_in)
        (enable_in && read_in && addr_in == `IFTM_ADDR_CODE) |=> rdata_out == {27'h0, $past(keypad_code_out)};
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("code read wrong"); // code register readback
endmodule
`default_nettype wire

/* rtl/iftm_defines.svh */
`ifndef IFTM_DEFINES_SVH
`define IFTM_DEFINES_SVH

// register word addresses
`define IFTM_ADDR_CTRL      4'h0
`define IFTM_ADDR_CONFIG    4'h1
`define IFTM_ADDR_ACTIVE    4'h2
`define IFTM_ADDR_WARN      4'h3
`define IFTM_ADDR_CODE      4'h4
`define IFTM_ADDR_HISTORY   4'h5
`define IFTM_ADDR_LEVEL     4'h6

// control register bits
`define IFTM_CTRL_RESET_BIT 0

// config register fields
`define IFTM_CFG_OVL_EN_BIT    0
`define IFTM_CFG_THERM_EN_BIT  1
`define IFTM_CFG_PHASE_LO      2
`define IFTM_CFG_PHASE_HI      3
`define IFTM_CFG_PHASE_BIT     1
`define IFTM_CFG_SRC_POL_BIT   4
`define IFTM_CFG_EXTA_EN_BIT   5
`define IFTM_CFG_EXTB_EN_BIT   6
`define IFTM_CFG_RLY1_LO       8
`define IFTM_CFG_RLY1_HI       12
`define IFTM_CFG_RLY2_LO       16
`define IFTM_CFG_RLY2_HI       20
`define IFTM_RELAY_BRAKE_FN    5'h13
`define IFTM_CFG_RESET         32'h0000_0000

// trip source count and no-trip code
`define IFTM_NUM_SRC           17
`define IFTM_CODE_NONE         5'h1f

// timing
`define IFTM_CLK_HZ            100000000
`define IFTM_LINK_LOSS_MS      500
`define IFTM_IO_LOSS_MS        2000
`define IFTM_RECHARGE_MS       1000
`define IFTM_LINK_LOSS_CYC     ((`IFTM_CLK_HZ / 1000) * `IFTM_LINK_LOSS_MS)
`define IFTM_IO_LOSS_CYC       ((`IFTM_CLK_HZ / 1000) * `IFTM_IO_LOSS_MS)
`define IFTM_RECHARGE_CYC      ((`IFTM_CLK_HZ / 1000) * `IFTM_RECHARGE_MS)

`endif

/* rtl/iftm_pkg.sv */
`default_nettype none
package iftm_pkg;
    // one bit per trip source, index is also priority (0 = highest)
    typedef enum logic [4:0] {
        SRC_CHARGE   = 5'h00,
        SRC_OVERCUR  = 5'h01,
        SRC_GROUND   = 5'h02,
        SRC_OVERVOLT = 5'h03,
        SRC_UNDERVLT = 5'h04,
        SRC_IOBOARD  = 5'h05,
        SRC_LINK     = 5'h06,
        SRC_SENSOR   = 5'h07,
        SRC_HEATSINK = 5'h08,
        SRC_DRV_OVL  = 5'h09,
        SRC_MOT_OVL  = 5'h0a,
        SRC_THERMAL  = 5'h0b,
        SRC_PHASE    = 5'h0c,
        SRC_EXT_A    = 5'h0d,
        SRC_EXT_B    = 5'h0e,
        SRC_BRAKE    = 5'h0f,
        SRC_FAN      = 5'h10
    } iftm_src_type;

    typedef enum logic [1:0] {
        IO_WAIT = 2'b00,
        IO_UP   = 2'b01,
        IO_LOST = 2'b10
    } iftm_io_state_type;

    // raw fault detections from the power stage
    typedef struct packed {
        logic       overload_level;
        logic       overcurrent_200;
        logic       overvoltage;
        logic       undervoltage;
        logic       ground_fault;
        logic       thermal_model;
        logic [2:0] phase_open;
        logic       drive_overload;
        logic       charge_fault;
        logic       heatsink_hot;
        logic       temp_sensor_bad;
        logic       fan_error;
        logic       ext_a_pin;
        logic       ext_b_pin;
        logic       link_up;
        logic       io_link_up;
        logic       brake_active;
        logic       below_brake_current;
    } iftm_fault_in_type;

    typedef struct packed {
        logic [16:0]       active;
        logic [16:0]       history;
        logic [4:0]        code;
        logic              halt;
        logic              warning;
        logic [31:0]       cfg;
        logic [31:0]       rdata;
        logic [31:0]       link_cnt;
        logic [31:0]       io_cnt;
        logic [31:0]       uv_cnt;
        logic              uv_recent;
        logic              prev_uv;
        iftm_io_state_type io_state;
    } iftm_state_type;
endpackage
`default_nettype wire

/* testbench/iftm_stage_model.sv */
`default_nettype none
// ----------------------------------------
// power stage, terminals and keypad button
// ----------------------------------------
module iftm_stage_model
    import iftm_pkg::*;
(
    // fault condition per trip source, terminal polarity, operator button
    input  wire logic [16:0]         cond_in,
    input  wire logic                src_pol_in,
    input  wire logic                button_in,
    // pins toward the trip manager
    output var iftm_fault_in_type    fault_out,
    output logic                     reset_trip_out
);
    timeunit 1ns;
    timeprecision 100ps;

    always_comb begin
        fault_out                     = '0;
        fault_out.charge_fault        = cond_in[0];
        fault_out.overcurrent_200     = cond_in[1];
        fault_out.ground_fault        = cond_in[2];
        fault_out.overvoltage         = cond_in[3];
        fault_out.undervoltage        = cond_in[4];
        fault_out.io_link_up          = ~cond_in[5];
        fault_out.link_up             = ~cond_in[6];
        fault_out.temp_sensor_bad     = cond_in[7];
        fault_out.heatsink_hot        = cond_in[8];
        fault_out.drive_overload      = cond_in[9];
        fault_out.overload_level      = cond_in[10];
        fault_out.thermal_model       = cond_in[11];
        fault_out.phase_open          = {2'b00, cond_in[12]};
        // closed contact reads low in sink mode, high in source mode
        fault_out.ext_a_pin           = cond_in[13] ~^ src_pol_in;
        fault_out.ext_b_pin           = cond_in[14] ^ src_pol_in;
        fault_out.brake_active        = cond_in[15];
        fault_out.below_brake_current = cond_in[15];
        fault_out.fan_error           = cond_in[16];
    end

    assign reset_trip_out = button_in;
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
`include "iftm_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import iftm_pkg::*;

    localparam int LINK_CYC = 20;
    localparam int IO_CYC   = 40;
    localparam int RECH_CYC = 30;

    logic              clk_in     = 1'b0;
    logic              reset_in   = 1'b1;
    logic              enable_in  = 1'b1;
    logic [16:0]       cond       = '0;
    logic              src_pol    = 1'b0;
    logic              button     = 1'b0;
    logic [3:0]        addr       = 4'h0;
    logic [31:0]       wdata      = 32'h0;
    logic              wr_stb     = 1'b0;
    logic              rd_stb     = 1'b0;
    logic [31:0]       rdata;
    logic              halt;
    logic              warning;
    logic [4:0]        code;
    logic [16:0]       active;
    logic              reset_trip;
    iftm_fault_in_type fault;
    int                bad_count  = 0;
    int                checks     = 0;

    always #5 clk_in = ~clk_in;

    iftm_stage_model iftm_stage_model_i (.cond_in(cond), .src_pol_in(src_pol), .button_in(button),
                                         .fault_out(fault), .reset_trip_out(reset_trip));

    iftm_trip_manager #(.LINK_LOSS_CYC(LINK_CYC), .IO_LOSS_CYC(IO_CYC), .RECHARGE_CYC(RECH_CYC))
        iftm_trip_manager_i (.clk_in(clk_in), .reset_in(reset_in), .enable_in(enable_in), .fault_in(fault),
                             .reset_trip_in(reset_trip), .addr_in(addr), .wdata_in(wdata), .write_in(wr_stb),
                             .read_in(rd_stb), .rdata_out(rdata), .halt_out(halt), .warning_out(warning),
                             .keypad_code_out(code), .active_out(active));

    // ----------------------------------------
    // expectations and bus tasks
    // ----------------------------------------
    function automatic logic [4:0] exp_code(input logic [16:0] m);
        for (int i = 0; i < 17; i++) if (m[i]) return i[4:0];
        return `IFTM_CODE_NONE;
    endfunction

    // timed sources 5 and 6 are left out, they need a long absence
    function automatic logic [16:0] exp_mask(input logic [16:0] c, input logic [31:0] g);
        logic [16:0] m;
        m     = c & 17'h1039f;
        m[10] = c[10] & g[0];
        m[11] = c[11] & g[1];
        m[12] = c[12] & g[3];
        m[13] = c[13] & g[5];
        m[14] = c[14] & g[6];
        m[15] = c[15] & ((g[12:8] == `IFTM_RELAY_BRAKE_FN) || (g[20:16] == `IFTM_RELAY_BRAKE_FN));
        return m;
    endfunction

    task automatic report_and_stop();
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk_in);
        wr_stb <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_in);
        rd_stb <= 1'b0;
        @(posedge clk_in);
        d = rdata;
    endtask

    task automatic press();
        button <= 1'b1;
        @(posedge clk_in);
        button <= 1'b0;
        cyc(3);
    endtask

    task automatic power_cycle();
        reset_in <= 1'b1;
        cyc(2);
        reset_in <= 1'b0;
        cyc(3);
    endtask

    task automatic expect_out(input logic [16:0] m);
        check("active", active, m);
        check("code", code, exp_code(m));
        check("halt", halt, |m[15:0]);
        check("warning", warning, m[16]);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] g;
        logic [16:0] m;
        void'($urandom(45908));
        cyc(6);
        reset_in <= 1'b0;
        cyc(2);
        rd(`IFTM_ADDR_CONFIG, d);
        check("config after reset", d, `IFTM_CFG_RESET);
        expect_out('0);
        rd(4'hf, d);
        check("unmapped read", d, 32'h0);
        // level class undervoltage, held past the quick-return window
        cond <= 17'h00010;
        cyc(3);
        expect_out(17'h00010);
        cyc(2 * RECH_CYC);
        cond <= '0;
        cyc(3);
        expect_out('0);
        rd(`IFTM_ADDR_HISTORY, d);
        check("history undervoltage", d[4], 1'b0);
        // fatal charging fault survives trip reset
        cond <= 17'h00001;
        cyc(3);
        expect_out(17'h00001);
        cond <= '0;
        press();
        expect_out(17'h00001);
        power_cycle();
        expect_out('0);
        // quick return of bus voltage
        cond <= 17'h00010;
        cyc(5);
        cond <= '0;
        cyc(3);
        check("charge after quick return", active[0], 1'b1);
        power_cycle();
        // frozen while disabled, then latched overcurrent
        enable_in <= 1'b0;
        cond      <= 17'h00002;
        cyc(4);
        expect_out('0);
        enable_in <= 1'b1;
        cyc(3);
        expect_out(17'h00002);
        press();
        expect_out(17'h00002);
        cond <= '0;
        cyc(3);
        expect_out(17'h00002);
        rd(`IFTM_ADDR_ACTIVE, d);
        check("active register", d, 32'h2);
        rd(`IFTM_ADDR_CODE, d);
        check("code register", d, 32'h1);
        wr(`IFTM_ADDR_CTRL, 32'h1);
        cyc(2);
        expect_out('0);
        // internal link loss just short of and past the limit
        cond <= 17'h00040;
        cyc(LINK_CYC - 5);
        check("link early", active[6], 1'b0);
        cyc(10);
        check("link late", active[6], 1'b1);
        cond <= '0;
        press();
        expect_out('0);
        // io board link loss, then power-up without the link
        cond <= 17'h00020;
        cyc(IO_CYC - 5);
        check("io early", active[5], 1'b0);
        cyc(10);
        check("io late", active[5], 1'b1);
        power_cycle();
        check("io at power-up", active[5], 1'b1);
        cond <= '0;
        cyc(2);
        press();
        expect_out('0);
        // random groups of simultaneous trips under random settings
        for (int n = 0; n < 40; n++) begin
            g        = $urandom & 32'h7f;
            g[12:8]  = $urandom_range(1) ? `IFTM_RELAY_BRAKE_FN : 5'h03;
            g[20:16] = $urandom_range(1) ? `IFTM_RELAY_BRAKE_FN : 5'h07;
            m        = (n == 0) ? 17'h1ff8e : ($urandom & 17'h1ff8e);
            src_pol  <= g[4];
            wr(`IFTM_ADDR_CONFIG, g);
            // a polarity change can briefly look like a closed contact
            press();
            rd(`IFTM_ADDR_CONFIG, d);
            check("config readback", d, g);
            expect_out('0);
            cond <= m;
            cyc(3);
            expect_out(exp_mask(m, g));
            rd(`IFTM_ADDR_WARN, d);
            check("warn register", |d, m[16]);
            rd(`IFTM_ADDR_LEVEL, d);
            check("level register", d, {15'h0, exp_mask(m, g)});
            cond <= '0;
            cyc(3);
            expect_out(exp_mask(m, g));
            press();
            expect_out('0);
        end
        report_and_stop();
    end

    initial begin
        cyc(20000);
        bad_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
